/* prc_pkg.sv */
// package of constants and types for the pressure reading command responder
// Contract
// - single ascii read returns one compensated reading as ascii text
// - read at address 90 to 99 is sequential, gated by changes-only
// - single read while continuous sends one ascii reading, then resumes
// - group or global single read sends nothing if reading already read; the code holds back only in changes-only mode
// - latest reading is sent only if output buffer space exists
// - group read without buffer space replies echo with exclamation mark
// - zero pressure with range or parity fault replies !0.0000
// - no valid reading replies with two dots instead of a value
// - continuous ascii read repeats readings at the configured rate
// - dollar suspends readings; initialize ends continuous; 99 stops all
// - on rs-485 continuous needs transmit option, else only one reading
// - single binary reply is header, four data bytes, carriage return
// - checksum option inserts checksum before carriage return
// - checksum makes low six bits of character sum zero, excluding cr
// - analog select options send analog value with tilde header
// - missing binary reading sends header, address bits, question marks
// - continuous binary read streams readings in six byte format
// - reading rate 0 to 10; n skips n times 100 identical readings
// - skip count applies only in changes-only mode
// - changes-only continuous sends one reading then waits for change
// - extended binary: 7-bit address, 17-bit magnitude, sign in header
package prc_pkg;
  typedef enum logic [2:0] {
    prc_cmd_none, prc_cmd_single_ascii_read, prc_cmd_continuous_ascii_read,
    prc_cmd_single_binary_read, prc_cmd_continuous_binary_read,
    prc_cmd_initialize
  } prc_cmd_t;

  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_EQ = 8'h3d;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_BIN_BASE = 8'h40;

  localparam logic [6:0] ADDR_GROUP_LO = 7'h5a; // 90
  localparam logic [6:0] ADDR_GLOBAL = 7'h63; // 99
  localparam logic [3:0] RATE_MAX = 4'ha;
  localparam logic [10:0] SKIP_UNIT = 11'h064; // 100
  localparam int ASCII_DIGITS = 5;
  localparam logic [2:0] DEC_POS_RST = 3'h3;

  // register layout on the wishbone bus (word addresses are byte >> 2)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_ANALOG = 8'h10;
  // control register bit positions
  localparam int CTL_CHANGES_ONLY = 0;
  localparam int CTL_CHECKSUM = 1;
  localparam int CTL_EXTENDED = 2;
  localparam int CTL_RS485 = 3;
  localparam int CTL_CONT_TX = 4;
  localparam int CTL_ANALOG_SEL = 5;
  localparam int CTL_ASCII_EN = 6;
  localparam int CTL_BIN_EN = 7;
  localparam int CTL_DEC_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_03c0;
  localparam logic [6:0] DEV_ADDR_RST = 7'h01;
endpackage

/* prc_responder.sv */
// pressure reading command responder: command decode, reply framing
`timescale 1ns/1ps
module prc_responder (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // decoded request from the receive path
  input wire logic req_valid_i,
  input wire logic [2:0] req_cmd_i,
  input wire logic [6:0] req_addr_i,
  input wire logic suspend_i,
  // reading source
  input wire logic reading_valid_i,
  input wire logic reading_new_i,
  input wire logic reading_changed_i,
  input wire logic reading_neg_i,
  input wire logic [16:0] reading_mag_i,
  input wire logic [16:0] analog_mag_i,
  input wire logic temp_fault_i,
  input wire logic parity_fault_i,
  // transmit byte stream
  input wire logic tx_space_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic continuous_o
);
  typedef enum logic [1:0] {st_idle, st_send} prc_st_t;

  logic [31:0] ctrl_q;
  logic [3:0] rate_q;
  logic [6:0] dev_addr_q;
  logic ack_q;
  logic wb_hit;
  logic [31:0] rd_d;

  prc_st_t st_q;
  logic [7:0] buf_q [0:13];
  logic [3:0] len_q;
  logic [3:0] idx_q;
  logic cont_q;
  logic cont_bin_q;
  logic read_seen_q;
  logic [10:0] skip_q;
  logic first_q;
  logic first_bin_q;
  logic cont_pend_q;
  logic nospace_q;
  logic [2:0] dec_pos;

  logic is_group;
  logic is_mine;
  logic is_single;
  logic is_cont;
  logic bin_req;
  logic cont_allowed;
  logic single_go;
  logic cont_go;
  logic emit_bin;
  logic emit_ascii;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_ack_o = ack_q;

  // register bus: one wait state, ack for every address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= prc_pkg::CTRL_RST;
      rate_q <= 4'h0;
      dev_addr_q <= prc_pkg::DEV_ADDR_RST;
    end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        prc_pkg::REG_CTRL: begin
          ctrl_q[7:0] <= wb_dat_i[7:0];
        end
        prc_pkg::REG_RATE: begin
          if (wb_dat_i[3:0] <= prc_pkg::RATE_MAX) begin
            rate_q <= wb_dat_i[3:0];
          end
        end
        prc_pkg::REG_ADDR: begin
          dev_addr_q <= wb_dat_i[6:0];
        end
        default: begin
        end
      endcase
      if (wb_adr_i == prc_pkg::REG_CTRL && wb_sel_i[1]) begin
        ctrl_q[10:8] <= wb_dat_i[10:8];
      end
    end
  end

  always_comb begin
    case (wb_adr_i)
      prc_pkg::REG_CTRL: rd_d = {21'h00_0000, ctrl_q[10:0]};
      prc_pkg::REG_RATE: rd_d = {28'h000_0000, rate_q};
      prc_pkg::REG_ADDR: rd_d = {25'h000_0000, dev_addr_q};
      prc_pkg::REG_STATUS: rd_d = {26'h000_0000, nospace_q, read_seen_q,
                                    cont_bin_q, cont_q, st_q == st_send,
                                    reading_valid_i};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      wb_dat_o <= rd_d;
    end
  end

  // request classification
  assign is_group = req_addr_i >= prc_pkg::ADDR_GROUP_LO;
  assign is_single = req_cmd_i == prc_pkg::prc_cmd_single_ascii_read ||
                     req_cmd_i == prc_pkg::prc_cmd_single_binary_read;
  assign is_cont = req_cmd_i == prc_pkg::prc_cmd_continuous_ascii_read ||
                   req_cmd_i == prc_pkg::prc_cmd_continuous_binary_read;
  assign bin_req = req_cmd_i == prc_pkg::prc_cmd_single_binary_read ||
                   req_cmd_i == prc_pkg::prc_cmd_continuous_binary_read;
  assign cont_allowed = !ctrl_q[prc_pkg::CTL_RS485] ||
                        ctrl_q[prc_pkg::CTL_CONT_TX];
  // reads answer at the own address or any group or global address
  assign is_mine = req_addr_i == dev_addr_q || is_group;
  // more than five places would put the point over the sign or the equals sign of the reply
  assign dec_pos = ctrl_q[10:8] > 3'h5 ? 3'h5 : ctrl_q[10:8];

  // continuous emission: every new reading, or changes only with skip count
  always_comb begin
    cont_go = 1'b0;
    if (cont_q && !suspend_i && reading_new_i) begin
      if (!ctrl_q[prc_pkg::CTL_CHANGES_ONLY]) begin
        cont_go = 1'b1;
      end else if (reading_changed_i) begin
        cont_go = 1'b1;
      end else if (rate_q == 4'h0) begin
        cont_go = 1'b0;
      end else begin
        cont_go = skip_q == 11'(rate_q * prc_pkg::SKIP_UNIT);
      end
    end
  end

  // identical-reading skip counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_q <= 11'h000;
    end else if (cont_go || (req_valid_i && is_cont)) begin
      skip_q <= 11'h000;
    end else if (cont_q && reading_new_i && !suspend_i) begin
      skip_q <= skip_q + 11'h001;
    end
  end

  assign single_go = req_valid_i && is_single && is_mine &&
                     (!is_group || !read_seen_q ||
                      !ctrl_q[prc_pkg::CTL_CHANGES_ONLY]);

  // continuous mode state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cont_q <= 1'b0;
      cont_bin_q <= 1'b0;
    end else if (req_valid_i &&
                 req_cmd_i == prc_pkg::prc_cmd_initialize &&
                 (req_addr_i == dev_addr_q ||
                  req_addr_i == prc_pkg::ADDR_GLOBAL)) begin
      cont_q <= 1'b0;
    end else if (req_valid_i && is_cont && is_mine && cont_allowed) begin
      cont_q <= 1'b1;
      cont_bin_q <= bin_req;
    end
  end

  // already-read flag for the current integration cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_seen_q <= 1'b0;
    end else if (st_q == st_idle && (single_go || first_q)) begin
      read_seen_q <= 1'b1;
    end else if (reading_new_i) begin
      read_seen_q <= 1'b0;
    end
  end

  // one reply owed to a continuous request whatever the mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_q <= 1'b0;
      first_bin_q <= 1'b0;
    end else if (req_valid_i && is_cont && is_mine) begin
      first_q <= 1'b1;
      first_bin_q <= bin_req;
    end else if (st_q == st_idle && !single_go && !req_valid_i &&
                 tx_space_i) begin
      first_q <= 1'b0;
    end
  end

  // a reading that falls due while a reply goes out is sent after it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cont_pend_q <= 1'b0;
    end else if (cont_go && st_q == st_send) begin
      cont_pend_q <= 1'b1;
    end else if (st_q == st_idle || !cont_q) begin
      cont_pend_q <= 1'b0;
    end
  end

  // a single read during continuous output always answers in ascii
  assign emit_ascii = single_go ?
    (cont_q || req_cmd_i == prc_pkg::prc_cmd_single_ascii_read) :
    (first_q ? !first_bin_q : !cont_bin_q);
  assign emit_bin = !emit_ascii;

  // reply assembly and byte sequencing
  always_ff @(posedge clk_i) begin
    logic [7:0] hdr;
    logic [7:0] sum;
    logic [23:0] dat;
    int i;
    hdr = 8'h00;
    sum = 8'h00;
    dat = 24'h00_0000;
    i = 0;
    if (rst_i) begin
      st_q <= st_idle;
      len_q <= 4'h0;
      idx_q <= 4'h0;
      nospace_q <= 1'b0;
      for (i = 0; i < 14; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      case (st_q)
        st_idle: begin
          if (single_go || (first_q && !req_valid_i) || cont_go ||
              cont_pend_q) begin
            if (!tx_space_i) begin
              nospace_q <= 1'b1;
              if (req_valid_i && is_group) begin
                buf_q[0] <= prc_pkg::CH_STAR;
                buf_q[1] <= prc_pkg::CH_ZERO + 8'(req_addr_i / 10);
                buf_q[2] <= prc_pkg::CH_ZERO + 8'(req_addr_i % 10);
                buf_q[3] <= prc_pkg::CH_P;
                buf_q[4] <= prc_pkg::CH_ZERO + (bin_req ? 8'h03 : 8'h01);
                buf_q[5] <= prc_pkg::CH_BANG;
                buf_q[6] <= prc_pkg::CH_CR;
                len_q <= 4'h7;
                idx_q <= 4'h0;
                st_q <= st_send;
              end
            end else if (emit_bin) begin
              dat = {dev_addr_q,
                     ctrl_q[prc_pkg::CTL_ANALOG_SEL] ? analog_mag_i :
                     reading_mag_i};
              hdr = ctrl_q[prc_pkg::CTL_ANALOG_SEL] ? prc_pkg::CH_TILDE :
                    (prc_pkg::CH_BIN_BASE |
                     {7'h00, ctrl_q[prc_pkg::CTL_EXTENDED] &
                      reading_neg_i});
              buf_q[0] <= hdr;
              buf_q[1] <= {2'b01, dat[23:18]};
              if (!reading_valid_i || !ctrl_q[prc_pkg::CTL_BIN_EN]) begin
                for (i = 2; i < 5; i++) begin
                  buf_q[i] <= prc_pkg::CH_QM;
                end
                sum = hdr + {2'b01, dat[23:18]} + 8'(3 * prc_pkg::CH_QM);
              end else begin
                buf_q[2] <= {2'b01, dat[17:12]};
                buf_q[3] <= {2'b01, dat[11:6]};
                buf_q[4] <= {2'b01, dat[5:0]};
                sum = hdr + {2'b01, dat[23:18]} + {2'b01, dat[17:12]} +
                      {2'b01, dat[11:6]} + {2'b01, dat[5:0]};
              end
              if (ctrl_q[prc_pkg::CTL_CHECKSUM]) begin
                buf_q[5] <= {2'b01, 6'(8'h00 - sum)};
                buf_q[6] <= prc_pkg::CH_CR;
                len_q <= 4'h7;
              end else begin
                buf_q[5] <= prc_pkg::CH_CR;
                len_q <= 4'h6;
              end
              idx_q <= 4'h0;
              st_q <= st_send;
            end else begin
              buf_q[0] <= prc_pkg::CH_HASH;
              buf_q[1] <= prc_pkg::CH_ZERO + 8'(dev_addr_q / 10);
              buf_q[2] <= prc_pkg::CH_ZERO + 8'(dev_addr_q % 10);
              buf_q[3] <= prc_pkg::CH_C;
              buf_q[4] <= prc_pkg::CH_P;
              if (!reading_valid_i || !ctrl_q[prc_pkg::CTL_ASCII_EN]) begin
                buf_q[5] <= prc_pkg::CH_EQ;
                buf_q[6] <= prc_pkg::CH_DOT;
                buf_q[7] <= prc_pkg::CH_DOT;
                buf_q[8] <= prc_pkg::CH_CR;
                len_q <= 4'h9;
              end else if (reading_mag_i == 17'h0_0000 &&
                           (temp_fault_i || parity_fault_i)) begin
                buf_q[5] <= prc_pkg::CH_BANG;
                buf_q[6] <= prc_pkg::CH_ZERO;
                buf_q[7] <= prc_pkg::CH_DOT;
                for (i = 8; i < 12; i++) begin
                  buf_q[i] <= prc_pkg::CH_ZERO;
                end
                buf_q[12] <= prc_pkg::CH_CR;
                len_q <= 4'hd;
              end else begin
                buf_q[5] <= prc_pkg::CH_EQ;
                buf_q[6] <= reading_neg_i ? prc_pkg::CH_MINUS :
                            prc_pkg::CH_PLUS;
                dat = {7'h00, reading_mag_i};
                // five digits, the last dec_pos of them after the point
                for (i = 4; i >= 0; i--) begin
                  buf_q[7 + i + ((i >= 5 - int'(dec_pos)) ? 1 : 0)]
                    <= prc_pkg::CH_ZERO + 8'(dat % 10);
                  dat = 24'(dat / 10);
                end
                buf_q[12 - int'(dec_pos)] <= prc_pkg::CH_DOT;
                buf_q[13] <= prc_pkg::CH_CR;
                len_q <= 4'he;
              end
              idx_q <= 4'h0;
              st_q <= st_send;
            end
          end
        end
        st_send: begin
          if (tx_ready_i) begin
            if (idx_q + 4'h1 == len_q) begin
              st_q <= st_idle;
              nospace_q <= 1'b0;
            end
            idx_q <= idx_q + 4'h1;
          end
        end
        default: begin
          st_q <= st_idle;
        end
      endcase
    end
  end

  assign tx_valid_o = st_q == st_send;
  assign continuous_o = cont_q;
  assign tx_data_o = buf_q[idx_q];
endmodule

/* prc_responder_properties.sv */
// concurrent checks on the responder's ports, bound into every instance
`timescale 1ns/1ps
module prc_responder_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic req_valid_i,
  input wire logic [2:0] req_cmd_i,
  input wire logic [6:0] req_addr_i,
  input wire logic tx_space_i,
  input wire logic tx_ready_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic continuous_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without a request");
  chk_byte_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed while stalled");
  chk_reply_start: assert property (req_valid_i && !tx_valid_o &&
    tx_space_i && req_addr_i == 7'h01 && req_cmd_i inside {3'h1, 3'h3}
    |=> tx_valid_o)
    else $error("read request not answered next cycle");
  chk_cont_start: assert property (req_valid_i && !tx_valid_o &&
    tx_space_i && req_addr_i == 7'h01 && req_cmd_i inside {3'h2, 3'h4}
    |=> ##1 tx_valid_o)
    else $error("continuous request not answered in two cycles");
  chk_no_space: assert property (req_valid_i && !tx_valid_o &&
    !tx_space_i && req_addr_i == 7'h01 |=> !tx_valid_o)
    else $error("reply sent without buffer space");
  chk_init_stop: assert property (req_valid_i && !tx_valid_o &&
    req_cmd_i == 3'h5 && req_addr_i == 7'h63 |=> !continuous_o)
    else $error("global initialize left continuous output on");
  chk_cont_cause: assert property ($rose(continuous_o) |->
    $past(req_valid_i && req_cmd_i inside {3'h2, 3'h4}))
    else $error("continuous output started without a request");
endmodule

bind prc_responder prc_responder_properties u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .req_valid_i, .req_cmd_i, .req_addr_i, .tx_space_i,
  .tx_ready_i, .tx_valid_o, .tx_data_o, .continuous_o);

/* prc_host_model.sv */
// host side byte sink: stalls on demand and records every reply byte
`timescale 1ns/1ps
module prc_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] got [$];

  // a slow host takes a byte only every other cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
      if (tx_valid_i && tx_ready_o) begin
        got.push_back(tx_data_i);
      end
    end
  end
endmodule

/* prc_responder_tb.sv */
// self-checking bench for the pressure reading command responder
`timescale 1ns/1ps
module prc_responder_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, tx_data_o, sum;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic req_valid_i, suspend_i, reading_valid_i, reading_new_i;
  logic reading_changed_i, reading_neg_i, temp_fault_i, parity_fault_i;
  logic tx_space_i, tx_ready_i, tx_valid_o, continuous_o, slow;
  logic [2:0] req_cmd_i;
  logic [6:0] req_addr_i;
  logic [16:0] reading_mag_i, analog_mag_i;
  logic [23:0] w;
  int fail_count, num_checks, cycles;

  prc_responder dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_i,
    .req_cmd_i, .req_addr_i, .suspend_i, .reading_valid_i, .reading_new_i,
    .reading_changed_i, .reading_neg_i, .reading_mag_i, .analog_mag_i,
    .temp_fault_i, .parity_fault_i, .tx_space_i, .tx_ready_i, .tx_valid_o,
    .tx_data_o, .continuous_o);
  prc_host_model host (.clk_i, .rst_i, .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk_str(string s);
    chk("reply length", s.len() + 1, host.got.size());
    for (int i = 0; i < s.len() && i < host.got.size(); i++)
      chk("reply byte", s[i], host.got[i]);
  endtask

  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic set_ctrl(logic [31:0] v);
    wb(1'b1, prc_pkg::REG_CTRL, v);
  endtask

  function automatic int crs();
    int c;
    c = 0;
    foreach (host.got[i]) if (host.got[i] == prc_pkg::CH_CR) c++;
    return c;
  endfunction

  // waits for ncr carriage returns; with ncr 0 it just lets silence pass
  task automatic wait_cr(int ncr);
    int n;
    n = 0;
    while (crs() < ncr && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (ncr == 0) repeat (30) @(posedge clk_i);
  endtask

  task automatic ask(logic [2:0] cmd, logic [6:0] adr, int ncr);
    host.got.delete();
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_cmd_i <= cmd;
    req_addr_i <= adr;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    wait_cr(ncr);
  endtask

  task automatic newr();
    @(posedge clk_i);
    reading_new_i <= 1'b1;
    @(posedge clk_i);
    reading_new_i <= 1'b0;
  endtask

  task automatic t_regs();
    wb(1'b0, prc_pkg::REG_CTRL, 32'h0000_0000);
    chk("ctrl reset", prc_pkg::CTRL_RST, rd);
    wb(1'b0, prc_pkg::REG_ADDR, 32'h0000_0000);
    chk("addr reset", {25'h000_0000, prc_pkg::DEV_ADDR_RST}, rd);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    wb(1'b0, prc_pkg::REG_RATE, 32'h0000_0000);
    chk("rate reset", 32'h0000_0000, rd);
    wb(1'b1, prc_pkg::REG_RATE, 32'h0000_000a);
    wb(1'b1, prc_pkg::REG_RATE, 32'h0000_000b);
    wb(1'b0, prc_pkg::REG_RATE, 32'h0000_0000);
    chk("rate max", 32'h0000_000a, rd);
    wb(1'b1, prc_pkg::REG_RATE, 32'h0000_0000);
  endtask

  task automatic t_ascii();
    ask(3'h1, 7'h01, 1);
    chk("ascii head", prc_pkg::CH_HASH, host.got[0]);
    chk("ascii eq", prc_pkg::CH_EQ, host.got[5]);
    chk_str("#01CP=+17.185");
    reading_valid_i <= 1'b0;
    ask(3'h1, 7'h01, 1);
    chk_str("#01CP=..");
    reading_valid_i <= 1'b1;
    reading_mag_i <= 17'h0_0000;
    for (int i = 0; i < 2; i++) begin
      temp_fault_i <= (i == 0);
      parity_fault_i <= (i == 1);
      ask(3'h1, 7'h01, 1);
      chk_str("#01CP!0.0000");
    end
    parity_fault_i <= 1'b0;
  endtask

  task automatic t_bin();
    slow <= 1'b1;
    reading_mag_i <= 17'h1_2345;
    w = {7'h01, 17'h1_2345};
    for (int k = 0; k < 2; k++) begin
      set_ctrl(k ? 32'h0000_03c2 : prc_pkg::CTRL_RST);
      ask(3'h3, 7'h01, 1);
      chk("bin size", 32'h0000_0006 + k, host.got.size());
      for (int i = 0; i < 4; i++)
        chk("bin data", {2'b01, w[23 - 6 * i -: 6]}, host.got[i + 1]);
      sum = 8'h00;
      for (int i = 0; i < 6; i++)
        sum = sum + host.got[i];
      if (k) chk("checksum", 32'h0000_0000, sum[5:0]);
    end
    set_ctrl(prc_pkg::CTRL_RST);
    reading_valid_i <= 1'b0;
    ask(3'h3, 7'h01, 1);
    chk("bin none", prc_pkg::CH_QM, host.got[host.got.size() - 2]);
    reading_valid_i <= 1'b1;
    set_ctrl(32'h0000_03e0);
    ask(3'h3, 7'h01, 1);
    chk("analog head", prc_pkg::CH_TILDE, host.got[0]);
    set_ctrl(prc_pkg::CTRL_RST);
    slow <= 1'b0;
  endtask

  task automatic t_cont();
    ask(3'h2, 7'h01, 1);
    chk("cont on", 32'h0000_0001, continuous_o);
    newr();
    wait_cr(2);
    newr();
    wait_cr(3);
    chk("cont count", 32'h0000_0003, crs());
    ask(3'h3, 7'h01, 1);
    chk("single in cont", prc_pkg::CH_HASH, host.got[0]);
    chk("cont resumes", 32'h0000_0001, continuous_o);
    suspend_i <= 1'b1;
    host.got.delete();
    newr();
    wait_cr(0);
    chk("suspended", 32'h0000_0000, host.got.size());
    ask(3'h5, 7'h63, 0);
    chk("cont off", 32'h0000_0000, continuous_o);
    suspend_i <= 1'b0;
    newr();
    wait_cr(0);
    chk("stopped", 32'h0000_0000, host.got.size());
    set_ctrl(32'h0000_03c8);
    ask(3'h4, 7'h01, 1);
    newr();
    wait_cr(0);
    chk("bus one", 32'h0000_0006, host.got.size());
    set_ctrl(32'h0000_03d8);
    ask(3'h4, 7'h01, 1);
    newr();
    wait_cr(2);
    chk("bin stream", 32'h0000_000c, host.got.size());
    ask(3'h5, 7'h01, 0);
    set_ctrl(prc_pkg::CTRL_RST);
  endtask

  task automatic t_group();
    tx_space_i <= 1'b0;
    ask(3'h1, 7'h01, 0);
    chk("no space", 32'h0000_0000, host.got.size());
    ask(3'h1, 7'h5a, 1);
    chk_str("*90P1!");
    tx_space_i <= 1'b1;
    set_ctrl(32'h0000_03c1);
    newr();
    ask(3'h1, 7'h5a, 1);
    ask(3'h1, 7'h5a, 0);
    chk("group reread", 32'h0000_0000, host.got.size());
    set_ctrl(prc_pkg::CTRL_RST);
    ask(3'h1, 7'h5a, 1);
    chk("group all", 32'h0000_0001, host.got.size() > 0);
    set_ctrl(32'h0000_03c1);
    ask(3'h2, 7'h01, 1);
    reading_changed_i <= 1'b0;
    newr();
    wait_cr(0);
    chk("no change", 32'h0000_0001, crs());
    reading_changed_i <= 1'b1;
    newr();
    wait_cr(2);
    chk("changed", 32'h0000_0002, crs());
    reading_changed_i <= 1'b0;
    wb(1'b1, prc_pkg::REG_RATE, 32'h0000_0001);
    repeat (100) newr();
    wait_cr(0);
    chk("skip hold", 32'h0000_0002, crs());
    newr();
    wait_cr(3);
    chk("skip send", 32'h0000_0003, crs());
    wb(1'b1, prc_pkg::REG_RATE, 32'h0000_0000);
    ask(3'h5, 7'h63, 0);
  endtask

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i, suspend_i} = 5'h00;
    {reading_new_i, reading_neg_i, temp_fault_i, parity_fault_i} = 4'h0;
    {reading_valid_i, reading_changed_i, tx_space_i, slow} = 4'he;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    req_cmd_i = 3'h0;
    req_addr_i = 7'h01;
    reading_mag_i = 17'h0_4321;
    analog_mag_i = 17'h0_1234;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_ascii();
    t_bin();
    t_cont();
    t_group();
    close_out();
  end
endmodule
